// ---- dv/branch_core_assertions.sv ----
// timing and target checks for branch_core, seen from its ports only.
// assumes a program memory that answers in the same cycle.
`timescale 1ns/1ns
module branch_core_checker (
    input wire i_mclk,
    input wire i_arst_n,
    input wire [7:0] i_code_byte,
    input wire [15:0] o_code_addr,
    input wire o_instr_done,
    input wire o_carry_flag,
    input wire [1:0] o_bank_select_field,
    input wire [7:0] o_main_operand_register
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_arst_n);
    reset_state_a:
    assert property (disable iff (1'b0) !i_arst_n [*2] |-> o_code_addr == 16'h0000
        && !o_instr_done && o_main_operand_register == 8'h00 && o_bank_select_field == 2'h0)
    else $error("state not cleared in reset");
    nop_single_a:
    assert property (o_instr_done && (i_code_byte == 8'h00 || i_code_byte == 8'hA5)
        |=> o_instr_done && o_code_addr == $past(o_code_addr) + 16'h1)
    else $error("no-op not one byte one cycle");
    carry_skip_a:
    assert property (o_instr_done && (i_code_byte == 8'h40 && !o_carry_flag
        || i_code_byte == 8'h50 && o_carry_flag)
        |=> !o_instr_done ##1 o_instr_done && o_code_addr == $past(o_code_addr, 2) + 16'h2)
    else $error("carry jump not taken wrong");
    zero_skip_a:
    assert property (o_instr_done && i_code_byte == 8'h60 && o_main_operand_register != 8'h00
        |=> !o_instr_done ##1 o_instr_done && o_code_addr == $past(o_code_addr, 2) + 16'h2)
    else $error("zero jump not taken wrong");
    short_jump_a:
    assert property (o_instr_done && i_code_byte == 8'h80 |=> !o_instr_done [*2] ##1
        o_instr_done && o_code_addr == $past(o_code_addr, 3) + 16'h2
        + {{8{$past(i_code_byte, 2) > 8'h7F}}, $past(i_code_byte, 2)})
    else $error("relative jump target wrong");
    long_jump_a:
    assert property (o_instr_done && i_code_byte == 8'h02 |=> !o_instr_done [*3] ##1
        o_instr_done && o_code_addr == {$past(i_code_byte, 3), $past(i_code_byte, 2)})
    else $error("long jump target wrong");
    short_target_a:
    assert property (o_instr_done && i_code_byte[3:0] == 4'h1 |=> !o_instr_done [*2] ##1
        o_instr_done && o_code_addr == ((($past(o_code_addr, 3) + 16'h2) & 16'hF800)
        | ({8'h00, $past(i_code_byte, 3) & 8'hE0} << 3) | {8'h00, $past(i_code_byte, 2)}))
    else $error("short target page wrong");
    indirect_len_a:
    assert property (o_instr_done && i_code_byte == 8'h73
        |=> !o_instr_done [*2] ##1 o_instr_done)
    else $error("indirect jump not three cycles");
    dec_reg_len_a:
    assert property (o_instr_done && i_code_byte[7:3] == 5'h1B
        |=> !o_instr_done ##[1:2] o_instr_done)
    else $error("register decrement length wrong");
endmodule // branch_core_checker
bind branch_core branch_core_checker checks (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
    .i_code_byte(i_code_byte), .o_code_addr(o_code_addr), .o_instr_done(o_instr_done),
    .o_carry_flag(o_carry_flag), .o_bank_select_field(o_bank_select_field),
    .o_main_operand_register(o_main_operand_register));

// ---- dv/branch_core_tb.sv ----
// self-checking bench for branch_core: each instruction is poked into
// the program memory model just before its fetch, then timed.
// assumes prog_memory answers fetches combinationally.
`timescale 1ns/1ns
module branch_core_tb;
    reg i_mclk;
    reg i_arst_n;
    wire [7:0] code;
    wire [15:0] o_code_addr;
    wire o_instr_done;
    wire o_carry_flag;
    wire [1:0] o_bank_select_field;
    wire [7:0] o_main_operand_register;
    integer bad_count;
    integer comparisons;
    integer cycles;
    reg [15:0] p;
    branch_core uut (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_code_byte(code),
        .o_code_addr(o_code_addr), .o_instr_done(o_instr_done), .o_carry_flag(o_carry_flag),
        .o_bank_select_field(o_bank_select_field),
        .o_main_operand_register(o_main_operand_register));
    prog_memory rom (.i_addr(o_code_addr), .o_data(code));
    task chk(input [63:0] nm, input [15:0] e, input [15:0] s);
        begin
            comparisons = comparisons + 1;
            if (s !== e) begin
                bad_count = bad_count + 1;
                $display("unexpected %0s exp %h got %h", nm, e, s);
            end
        end
    endtask
    // done marks the first cycle of the next instruction, so count to it
    task step(input integer n, input [15:0] t);
        integer k;
        begin
            k = 0;
            do begin
                @(posedge i_mclk);
                #1;
                k = k + 1;
            end while (o_instr_done !== 1'b1 && k < 20);
            if (n > 0) chk("cycles", n, k);
            chk("pc", t, o_code_addr);
            p = o_code_addr;
        end
    endtask
    task x(input [23:0] b, input integer n, input integer c, input [15:0] t);
        integer i;
        begin
            for (i = 0; i < n; i = i + 1) begin
                rom.mem[p + i] = b[8 * (n - 1 - i) +: 8];
            end
            step(c, t);
        end
    endtask
    function [15:0] tg(input [15:0] l, input [7:0] r);
        tg = p + l + {{8{r[7]}}, r};
    endfunction
    task end_sim;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, bad_count);
            if (bad_count == 0 && comparisons > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    initial begin
        i_mclk = 1'b0;
        forever #4 i_mclk = ~i_mclk;
    end
    // generous ceiling: the program needs under two hundred cycles
    always @(posedge i_mclk) begin
        cycles = cycles + 1;
        if (cycles == 2000) begin
            bad_count = bad_count + 1;
            end_sim;
        end
    end
    initial begin
        i_arst_n = 1'b0;
        bad_count = 0;
        comparisons = 0;
        cycles = 0;
        p = 16'h0000;
        repeat (2) @(posedge i_mclk);
        i_arst_n <= 1'b1;
        rom.mem[0] = 8'h00;
        chk("acc", 16'h0000, o_main_operand_register);
        chk("bank", 16'h0000, o_bank_select_field);
        step(0, 16'h0001);
        x(24'h0000A5, 1, 1, tg(1, 0));
        x(24'h75E080, 3, 3, tg(3, 0));
        chk("acc", 16'h0080, o_main_operand_register);
        x(24'h00A2E7, 2, 2, tg(2, 0));
        chk("carry", 16'h0001, o_carry_flag);
        x(24'h004003, 2, 3, tg(2, 8'h03));
        x(24'h0050F0, 2, 2, tg(2, 0));
        x(24'h00B0E7, 2, 2, tg(2, 0));
        chk("carry", 16'h0000, o_carry_flag);
        x(24'h005004, 2, 3, tg(2, 8'h04));
        x(24'h00A0E0, 2, 2, tg(2, 0));
        chk("carry", 16'h0001, o_carry_flag);
        x(24'h0082E0, 2, 2, tg(2, 0));
        chk("carry", 16'h0000, o_carry_flag);
        x(24'h0072E7, 2, 2, tg(2, 0));
        chk("carry", 16'h0001, o_carry_flag);
        x(24'h0092E0, 2, 2, tg(2, 0));
        chk("acc", 16'h0081, o_main_operand_register);
        x(24'h20E002, 3, 4, tg(3, 8'h02));
        x(24'h10E0FD, 3, 4, tg(3, 8'hFD));
        chk("acc", 16'h0080, o_main_operand_register);
        x(24'h10E0FD, 3, 3, tg(3, 0));
        x(24'h30E700, 3, 3, tg(3, 0));
        x(24'h006005, 2, 2, tg(2, 0));
        x(24'h007006, 2, 3, tg(2, 8'h06));
        x(24'h00807F, 2, 3, tg(2, 8'h7F));
        $display("test bit ops done");
        x(24'h75D018, 3, 3, tg(3, 0));
        chk("bank", 16'h0003, o_bank_select_field);
        chk("carry", 16'h0000, o_carry_flag);
        x(24'h751A01, 3, 3, tg(3, 0));
        x(24'h00DA05, 2, 2, tg(2, 0));
        x(24'hD51A02, 3, 4, tg(3, 8'h02));
        x(24'h75181A, 3, 3, tg(3, 0));
        x(24'hB6FF05, 3, 4, tg(3, 0));
        x(24'hBAFE01, 3, 4, tg(3, 8'h01));
        chk("carry", 16'h0000, o_carry_flag);
        x(24'hB48101, 3, 4, tg(3, 8'h01));
        chk("carry", 16'h0001, o_carry_flag);
        x(24'hB48009, 3, 3, tg(3, 0));
        chk("carry", 16'h0000, o_carry_flag);
        x(24'h00C0E0, 2, 2, tg(2, 0));
        x(24'hB50809, 3, 3, tg(3, 0));
        x(24'h75F055, 3, 3, tg(3, 0));
        x(24'hB5F002, 3, 4, tg(3, 8'h02));
        chk("carry", 16'h0000, o_carry_flag);
        $display("test compare done");
        x(24'h0207FE, 3, 4, 16'h07FE);
        x(24'h001120, 2, 3, ((p + 16'h2) & 16'hF800) | 16'h0020);
        x(24'h000022, 1, 5, 16'h0800);
        x(24'h120100, 3, 4, 16'h0100);
        x(24'h000022, 1, 5, 16'h0803);
        x(24'h000110, 2, 3, ((p + 16'h2) & 16'hF800) | 16'h0010);
        x(24'h000073, 1, 3, 16'h0080);
        x(24'h758312, 3, 3, tg(3, 0));
        x(24'h758234, 3, 3, tg(3, 0));
        x(24'h000073, 1, 3, 16'h12B4);
        $display("test branch done");
        @(posedge i_mclk);
        i_arst_n <= 1'b0;
        repeat (2) @(posedge i_mclk);
        chk("acc", 16'h0000, o_main_operand_register);
        chk("bank", 16'h0000, o_bank_select_field);
        i_arst_n <= 1'b1;
        step(0, 16'h0001);
        x(24'h000073, 1, 3, 16'h0000);
        x(24'hB5F002, 3, 3, tg(3, 0));
        $display("test reset done");
        end_sim;
    end
endmodule // branch_core_tb

// ---- dv/prog_memory.sv ----
// program memory model for the branch core: 64 kB of code bytes.
// assumes the bench pokes instructions into mem before they are fetched.
`timescale 1ns/1ns
module prog_memory (
    input wire [15:0] i_addr,
    output wire [7:0] o_data
);
    reg [7:0] mem [0:65535];
    integer i;
    // erased cells read as ones, so a stray fetch never sees the last byte
    initial begin
        for (i = 0; i < 65536; i = i + 1) begin
            mem[i] = 8'hFF;
        end
    end
    // answer is combinational: the core samples it at the fetch edge
    assign o_data = mem[i_addr];
endmodule // prog_memory

// ---- inc/branch_core_regs.vh ----
// constants for the branch and bit-operation core: register offsets,
// reset values, status bit positions, the bit-area base and opcodes.
// assumes it is included by its bare name from the design file.
`ifndef BRANCH_CORE_REGS_VH
`define BRANCH_CORE_REGS_VH

`define SFR_STACK_POINTER 8'h81
`define SFR_DATA_POINTER_LOW 8'h82
`define SFR_DATA_POINTER_HIGH 8'h83
`define SFR_STATUS_WORD 8'hD0
`define SFR_MAIN_OPERAND 8'hE0
`define SFR_SECOND_OPERAND 8'hF0

`define RST_STACK_POINTER 8'h07
`define RST_ZERO 8'h00

`define STATUS_CARRY_BIT 7
`define STATUS_BANK_HI 4
`define STATUS_BANK_LO 3
`define BIT_AREA_BASE 4'h2

`define OP_NOP 8'h00
`define OP_SPARE_NOP 8'hA5
`define OP_JUMP_CARRY 8'h40
`define OP_JUMP_NO_CARRY 8'h50
`define OP_JUMP_BIT 8'h20
`define OP_JUMP_NO_BIT 8'h30
`define OP_JUMP_CLEAR_BIT 8'h10
`define OP_AND_CARRY_BIT 8'h82
`define OP_AND_CARRY_NBIT 8'hB0
`define OP_OR_CARRY_BIT 8'h72
`define OP_OR_CARRY_NBIT 8'hA0
`define OP_BIT_TO_CARRY 8'hA2
`define OP_CARRY_TO_BIT 8'h92
`define OP_LONG_CALL 8'h12
`define OP_LONG_JUMP 8'h02
`define OP_RETURN 8'h22
`define OP_SHORT_REL_JUMP 8'h80
`define OP_JUMP_INDIRECT 8'h73
`define OP_JUMP_ZERO 8'h60
`define OP_JUMP_NONZERO 8'h70
`define OP_CMP_DIRECT 8'hB5
`define OP_CMP_IMM 8'hB4
`define OP_CMP_IND0 8'hB6
`define OP_CMP_IND1 8'hB7
`define OP_DEC_DIRECT 8'hD5
`define OP_MOVE_DIRECT_IMM 8'h75
`define OP_PUSH 8'hC0
`define OP_CMP_REG_HI 5'h17
`define OP_DEC_REG_HI 5'h1B
`define OP_SHORT_LOW 4'h1
`define OP_SHORT_CALL_BIT 4

`endif

// ---- verilog/branch_core.v ----
// branch, call, compare and carry-bit instruction core with its core
// special function registers and a 256-byte internal data memory.
// assumes a program memory that answers i_code_byte combinationally
// for o_code_addr within the same cycle, on the same clock.
`timescale 1ns/1ns
`include "branch_core_regs.vh"

//Contract
//- carry jumps: 2 bytes, 2/3 cycles
//- bit jumps: 3 bytes, 3/4; clear-variant clears
//- AND/OR bit or complement into carry
//- move bit to carry and back
//- short call/jump: 11-bit target, same page
//- long call/jump: 16-bit, 3 bytes, 4 cycles
//- relative offset from next instruction start
//- indirect jump to operand plus pointer
//- zero tests: 2 bytes, 2/3 cycles
//- compare-jump 3 bytes; 3/4 or 4/5
//- decrement-jump: register 2/3, direct 3/4
//- no-op one cycle; 0xA5 same
//- register operand in selected bank
//- indirect pointer only R0 or R1
//- direct low half RAM, high half SFR
//- pointer halves at 0x82/0x83, reset zero
//- stack pointer resets 0x07, pre-increments
//- main operand at 0xE0, reset zero
//- second operand at 0xF0, reset zero
//- bank field picks 8-byte register window
module branch_core (
    input wire i_mclk,
    input wire i_arst_n,
    input wire [7:0] i_code_byte,
    output wire [15:0] o_code_addr,
    output wire o_instr_done,
    output wire o_carry_flag,
    output wire [1:0] o_bank_select_field,
    output wire [7:0] o_main_operand_register
);

    reg rst_meta_q;
    reg rst_n_q;
    always @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    reg [7:0] ram [0:255];
    reg [15:0] pc_q;
    reg [15:0] fetch_q;
    reg [15:0] tgt_q;
    reg [2:0] cnt_q;
    reg [2:0] end_q;
    reg wait_q;
    reg done_q;
    reg [7:0] opc_q;
    reg [7:0] b1_q;
    reg [7:0] b2_q;
    reg [7:0] stack_pointer_q;
    reg [7:0] data_pointer_low_q;
    reg [7:0] data_pointer_high_q;
    reg [7:0] main_operand_q;
    reg [7:0] second_operand_q;
    reg [7:0] status_q;

    // {bytes, base cycles}; conditional forms add one cycle when taken
    function [5:0] timing;
        input [7:0] op;
        begin
            if (op[3:0] == `OP_SHORT_LOW)
                timing = {3'd2, 3'd3};
            else if (op[7:3] == `OP_CMP_REG_HI)
                timing = {3'd3, 3'd3};
            else if (op[7:3] == `OP_DEC_REG_HI)
                timing = {3'd2, 3'd2};
            else begin
                case (op)
                    `OP_JUMP_CARRY, `OP_JUMP_NO_CARRY: timing = {3'd2, 3'd2};
                    `OP_JUMP_ZERO, `OP_JUMP_NONZERO: timing = {3'd2, 3'd2};
                    `OP_JUMP_BIT, `OP_JUMP_NO_BIT,
                    `OP_JUMP_CLEAR_BIT: timing = {3'd3, 3'd3};
                    `OP_AND_CARRY_BIT, `OP_AND_CARRY_NBIT, `OP_OR_CARRY_BIT,
                    `OP_OR_CARRY_NBIT: timing = {3'd2, 3'd2};
                    `OP_BIT_TO_CARRY, `OP_CARRY_TO_BIT: timing = {3'd2, 3'd2};
                    `OP_LONG_CALL, `OP_LONG_JUMP: timing = {3'd3, 3'd4};
                    `OP_RETURN: timing = {3'd1, 3'd5};
                    `OP_SHORT_REL_JUMP: timing = {3'd2, 3'd3};
                    `OP_JUMP_INDIRECT: timing = {3'd1, 3'd3};
                    `OP_CMP_DIRECT, `OP_CMP_IMM: timing = {3'd3, 3'd3};
                    `OP_CMP_IND0, `OP_CMP_IND1: timing = {3'd3, 3'd4};
                    `OP_DEC_DIRECT: timing = {3'd3, 3'd3};
                    `OP_MOVE_DIRECT_IMM: timing = {3'd3, 3'd3};
                    `OP_PUSH: timing = {3'd2, 3'd2};
                    // undefined opcodes fall back to no-op timing, 0xA5 included
                    default: timing = {3'd1, 3'd1};
                endcase
            end
        end
    endfunction

    // direct space read: low half from RAM, high half from SFRs
    function [7:0] direct_read;
        input [7:0] a;
        begin
            if (!a[7])
                direct_read = ram[a];
            else begin
                case (a)
                    `SFR_STACK_POINTER: direct_read = stack_pointer_q;
                    `SFR_DATA_POINTER_LOW: direct_read = data_pointer_low_q;
                    `SFR_DATA_POINTER_HIGH: direct_read = data_pointer_high_q;
                    `SFR_STATUS_WORD: direct_read = {status_q[7:1], ^main_operand_q};
                    `SFR_MAIN_OPERAND: direct_read = main_operand_q;
                    `SFR_SECOND_OPERAND: direct_read = second_operand_q;
                    default: direct_read = 8'h00;
                endcase
            end
        end
    endfunction

    wire [7:0] op = (cnt_q == 3'd0 && !wait_q) ? i_code_byte : opc_q;
    wire [7:0] b1 = (cnt_q == 3'd1 && !wait_q) ? i_code_byte : b1_q;
    wire [7:0] b2 = (cnt_q == 3'd2 && !wait_q) ? i_code_byte : b2_q;
    wire [1:0] bank = status_q[`STATUS_BANK_HI:`STATUS_BANK_LO];
    wire cy = status_q[`STATUS_CARRY_BIT];

    reg [5:0] tim;
    reg [2:0] len;
    reg [2:0] total;
    reg [15:0] npc;
    reg [15:0] target;
    reg [15:0] newpc;
    reg [7:0] rel;
    reg [7:0] rn_addr;
    reg [7:0] ri_ptr;
    reg [7:0] rn_val;
    reg [7:0] ind_val;
    reg [7:0] bit_byte;
    reg [7:0] bbyte;
    reg [7:0] dval;
    reg [7:0] cmp_a;
    reg [7:0] cmp_b;
    reg [7:0] dec;
    reg bitv;
    reg taken;
    reg jump;
    reg dw_en;
    reg [7:0] dw_addr;
    reg [7:0] dw_data;
    reg cy_we;
    reg cy_new;
    reg sw1;
    reg sw2;
    reg [7:0] sw1_data;
    reg [7:0] sw2_data;
    reg [7:0] sp_new;

    always @* begin
        tim = timing(op);
        len = tim[5:3];
        npc = pc_q + {13'h0000, len};
        rn_addr = {3'b000, bank, op[2:0]};
        ri_ptr = ram[{3'b000, bank, 2'b00, op[0]}];
        rn_val = ram[rn_addr];
        ind_val = ram[ri_ptr];
        bit_byte = b1[7] ? {b1[7:3], 3'b000} : {`BIT_AREA_BASE, b1[6:3]};
        bbyte = direct_read(bit_byte);
        bitv = bbyte[b1[2:0]];
        dval = direct_read(b1);
        rel = b1;
        taken = 1'b0;
        jump = 1'b0;
        target = npc;
        dw_en = 1'b0;
        dw_addr = b1;
        dw_data = 8'h00;
        cy_we = 1'b0;
        cy_new = cy;
        sw1 = 1'b0;
        sw2 = 1'b0;
        sw1_data = npc[7:0];
        sw2_data = npc[15:8];
        sp_new = stack_pointer_q;
        cmp_a = main_operand_q;
        cmp_b = b1;
        dec = dval - 8'h01;
        if (op[3:0] == `OP_SHORT_LOW) begin
            jump = 1'b1;
            target = {npc[15:11], op[7:5], b1};
            if (op[`OP_SHORT_CALL_BIT]) begin
                sw1 = 1'b1;
                sw2 = 1'b1;
                sp_new = stack_pointer_q + 8'h02;
            end
        end else if (op[7:3] == `OP_CMP_REG_HI) begin
            cmp_a = rn_val;
            rel = b2;
            taken = cmp_a != cmp_b;
            cy_we = 1'b1;
            cy_new = cmp_a < cmp_b;
        end else if (op[7:3] == `OP_DEC_REG_HI) begin
            dec = rn_val - 8'h01;
            dw_en = 1'b1;
            dw_addr = rn_addr;
            dw_data = dec;
            taken = dec != 8'h00;
        end else begin
            case (op)
                `OP_JUMP_CARRY: taken = cy;
                `OP_JUMP_NO_CARRY: taken = !cy;
                `OP_JUMP_ZERO: taken = main_operand_q == 8'h00;
                `OP_JUMP_NONZERO: taken = main_operand_q != 8'h00;
                `OP_JUMP_BIT: begin
                    taken = bitv;
                    rel = b2;
                end
                `OP_JUMP_NO_BIT: begin
                    taken = !bitv;
                    rel = b2;
                end
                `OP_JUMP_CLEAR_BIT: begin
                    taken = bitv;
                    rel = b2;
                    dw_en = bitv;
                    dw_addr = bit_byte;
                    dw_data = bbyte & ~(8'h01 << b1[2:0]);
                end
                `OP_AND_CARRY_BIT: begin
                    cy_we = 1'b1;
                    cy_new = cy & bitv;
                end
                `OP_AND_CARRY_NBIT: begin
                    cy_we = 1'b1;
                    cy_new = cy & !bitv;
                end
                `OP_OR_CARRY_BIT: begin
                    cy_we = 1'b1;
                    cy_new = cy | bitv;
                end
                `OP_OR_CARRY_NBIT: begin
                    cy_we = 1'b1;
                    cy_new = cy | !bitv;
                end
                `OP_BIT_TO_CARRY: begin
                    cy_we = 1'b1;
                    cy_new = bitv;
                end
                `OP_CARRY_TO_BIT: begin
                    dw_en = 1'b1;
                    dw_addr = bit_byte;
                    dw_data = cy ? (bbyte | (8'h01 << b1[2:0]))
                                 : (bbyte & ~(8'h01 << b1[2:0]));
                end
                `OP_LONG_CALL: begin
                    jump = 1'b1;
                    target = {b1, b2};
                    sw1 = 1'b1;
                    sw2 = 1'b1;
                    sp_new = stack_pointer_q + 8'h02;
                end
                `OP_LONG_JUMP: begin
                    jump = 1'b1;
                    target = {b1, b2};
                end
                `OP_RETURN: begin
                    jump = 1'b1;
                    target = {ram[stack_pointer_q], ram[stack_pointer_q - 8'h01]};
                    sp_new = stack_pointer_q - 8'h02;
                end
                `OP_SHORT_REL_JUMP: taken = 1'b1;
                `OP_JUMP_INDIRECT: begin
                    jump = 1'b1;
                    target = {8'h00, main_operand_q}
                           + {data_pointer_high_q, data_pointer_low_q};
                end
                `OP_CMP_DIRECT, `OP_CMP_IMM, `OP_CMP_IND0, `OP_CMP_IND1: begin
                    if (op == `OP_CMP_DIRECT)
                        cmp_b = dval;
                    if (op == `OP_CMP_IND0 || op == `OP_CMP_IND1)
                        cmp_a = ind_val;
                    rel = b2;
                    taken = cmp_a != cmp_b;
                    cy_we = 1'b1;
                    cy_new = cmp_a < cmp_b;
                end
                `OP_DEC_DIRECT: begin
                    dw_en = 1'b1;
                    dw_data = dec;
                    rel = b2;
                    taken = dec != 8'h00;
                end
                `OP_MOVE_DIRECT_IMM: begin
                    dw_en = 1'b1;
                    dw_data = b2;
                end
                `OP_PUSH: begin
                    sw1 = 1'b1;
                    sw1_data = dval;
                    sp_new = stack_pointer_q + 8'h01;
                end
                default: taken = 1'b0;
            endcase
        end
        // short relative jump is unconditional, so its one-cycle bonus is folded in base
        if (op == `OP_SHORT_REL_JUMP)
            total = tim[2:0];
        else
            total = tim[2:0] + {2'b00, taken};
        if (taken)
            target = npc + {{8{rel[7]}}, rel};
        newpc = (jump || taken) ? target : npc;
    end

    wire last_fetch = !wait_q && (cnt_q == len - 3'd1);
    wire finish_now = last_fetch && (cnt_q == total - 3'd1);
    wire finish_wait = wait_q && (cnt_q == end_q);

    // memory has no reset; effects land on the last fetch edge
    always @(posedge i_mclk) begin
        if (last_fetch && dw_en && !dw_addr[7])
            ram[dw_addr] <= dw_data;
        if (last_fetch && sw1)
            ram[stack_pointer_q + 8'h01] <= sw1_data;
        if (last_fetch && sw2)
            ram[stack_pointer_q + 8'h02] <= sw2_data;
    end

    always @(posedge i_mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pc_q <= 16'h0000;
            fetch_q <= 16'h0000;
            tgt_q <= 16'h0000;
            cnt_q <= 3'd0;
            end_q <= 3'd0;
            wait_q <= 1'b0;
            done_q <= 1'b0;
            opc_q <= 8'h00;
            b1_q <= 8'h00;
            b2_q <= 8'h00;
            stack_pointer_q <= `RST_STACK_POINTER;
            data_pointer_low_q <= `RST_ZERO;
            data_pointer_high_q <= `RST_ZERO;
            main_operand_q <= `RST_ZERO;
            second_operand_q <= `RST_ZERO;
            status_q <= `RST_ZERO;
        end else begin
            done_q <= finish_now || finish_wait;
            if (!wait_q) begin
                case (cnt_q)
                    3'd0: opc_q <= i_code_byte;
                    3'd1: b1_q <= i_code_byte;
                    3'd2: b2_q <= i_code_byte;
                    default: opc_q <= opc_q;
                endcase
            end
            if (finish_now) begin
                pc_q <= newpc;
                fetch_q <= newpc;
                cnt_q <= 3'd0;
            end else if (last_fetch) begin
                tgt_q <= newpc;
                end_q <= total - 3'd1;
                wait_q <= 1'b1;
                cnt_q <= cnt_q + 3'd1;
            end else if (finish_wait) begin
                pc_q <= tgt_q;
                fetch_q <= tgt_q;
                cnt_q <= 3'd0;
                wait_q <= 1'b0;
            end else begin
                cnt_q <= cnt_q + 3'd1;
                if (!wait_q)
                    fetch_q <= fetch_q + 16'h0001;
            end
            if (last_fetch) begin
                stack_pointer_q <= sp_new;
                if (cy_we)
                    status_q[`STATUS_CARRY_BIT] <= cy_new;
                // a direct SFR write lands after the implicit updates and wins
                if (dw_en && dw_addr[7]) begin
                    case (dw_addr)
                        `SFR_STACK_POINTER: stack_pointer_q <= dw_data;
                        `SFR_DATA_POINTER_LOW: data_pointer_low_q <= dw_data;
                        `SFR_DATA_POINTER_HIGH: data_pointer_high_q <= dw_data;
                        `SFR_STATUS_WORD: status_q <= dw_data;
                        `SFR_MAIN_OPERAND: main_operand_q <= dw_data;
                        `SFR_SECOND_OPERAND: second_operand_q <= dw_data;
                        default: status_q <= status_q;
                    endcase
                end
            end
        end
    end

    assign o_code_addr = fetch_q;
    assign o_instr_done = done_q;
    assign o_carry_flag = cy;
    assign o_bank_select_field = bank;
    assign o_main_operand_register = main_operand_q;

endmodule // branch_core
